// *** i2srv_slave.sv ***
`timescale 1ns/1ps
`include "i2srv_map.svh"
module i2srv_slave (
   // clock and reset
   input  wire logic                  clk_sys_i,
   input  wire logic                  nrst_i,
   // bus pins; sda is open drain, enable low drives it low
   input  wire logic                  scl_i,
   input  wire logic                  sda_i,
   output logic                       sda_o,
   output logic                       sda_oe_n_o,
   // address override from nonvolatile store
   input  wire logic                  nvs_addr_valid_i,
   input  wire logic [6:0]            nvs_addr_i,
   // processing phase start from the device core
   input  wire logic                  phase_start_i,
   // register space of the device
   output i2srv_pkg::i2srv_req_s      req_o,
   input  wire logic [7:0]            read_data_byte_i,
   // state seen by the core
   output logic [6:0]                 bus_target_address_o,
   output logic                       busy_o
);
   typedef struct packed {
      i2srv_pkg::i2srv_state_e state;
      logic [7:0]              shift;
      logic [3:0]              bitcnt;
      logic                    rnw;
      logic                    ptr_phase;
      logic [7:0]              register_pointer_byte;
      logic [6:0]              my_addr;
      logic                    addr_loaded;
      logic                    sda_low;
      logic                    pend;
      logic [7:0]              pend_addr;
      logic [7:0]              write_data_byte;
      i2srv_pkg::i2srv_req_s   req;
   } i2srv_st_s;

   i2srv_pkg::i2srv_line_s line;
   i2srv_st_s              st_r;
   i2srv_st_s              st_nxt;

   i2srv_line u_line (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .scl_i     (scl_i),
      .sda_i     (sda_i),
      .line_o    (line)
   );

   always_comb begin
      st_nxt        = st_r;
      st_nxt.req.wr = 1'b0;
      st_nxt.req.rd = 1'b0;

      // address caught once after reset release, not under reset
      if (!st_r.addr_loaded) begin
         st_nxt.addr_loaded = 1'b1;
         if (nvs_addr_valid_i) begin
            st_nxt.my_addr = nvs_addr_i;
         end
      end

      // hold write until the core opens its next phase
      if (st_r.pend && phase_start_i) begin
         st_nxt.pend      = 1'b0;
         st_nxt.req.wr    = 1'b1;
         st_nxt.req.addr  = st_r.pend_addr;
         st_nxt.req.wdata = st_r.write_data_byte;
      end

      if (line.stop) begin
         st_nxt.state   = i2srv_pkg::ST_IDLE;
         st_nxt.sda_low = 1'b0;
      end else if (line.start) begin
         // repeated start too: keeps pointer for a following read
         st_nxt.state   = i2srv_pkg::ST_ADDR;
         st_nxt.bitcnt  = 4'h0;
         st_nxt.sda_low = 1'b0;
      end else begin
         unique case (st_r.state)
            i2srv_pkg::ST_IDLE: begin
               st_nxt.sda_low = 1'b0;
            end
            i2srv_pkg::ST_ADDR, i2srv_pkg::ST_WBYT: begin
               if (line.scl_rise) begin
                  st_nxt.shift  = {st_r.shift[6:0], line.sda};
                  st_nxt.bitcnt = st_r.bitcnt + 4'h1;
               end
               if (line.scl_fall && st_r.bitcnt == 4'h8) begin
                  st_nxt.bitcnt = 4'h0;
                  if (st_r.state == i2srv_pkg::ST_ADDR) begin
                     if (st_r.shift[7:1] == st_r.my_addr) begin
                        st_nxt.rnw     = st_r.shift[0];
                        st_nxt.sda_low = 1'b1;
                        st_nxt.state   = i2srv_pkg::ST_AACK;
                        st_nxt.ptr_phase = ~st_r.shift[0];
                     end else begin
                        st_nxt.state = i2srv_pkg::ST_IDLE;
                     end
                  end else begin
                     st_nxt.sda_low = 1'b1;
                     st_nxt.state   = i2srv_pkg::ST_WACK;
                     if (st_r.ptr_phase) begin
                        // pointer only: no register touched until data arrives
                        st_nxt.register_pointer_byte = st_r.shift;
                        st_nxt.ptr_phase             = 1'b0;
                     end else begin
                        // back-to-back writes faster than phases overwrite the pending byte
                        st_nxt.pend            = 1'b1;
                        st_nxt.pend_addr       = st_r.register_pointer_byte;
                        st_nxt.write_data_byte = st_r.shift;
                        st_nxt.register_pointer_byte = st_r.register_pointer_byte + 8'h01;
                     end
                  end
               end
            end
            i2srv_pkg::ST_AACK, i2srv_pkg::ST_WACK: begin
               if (line.scl_fall) begin
                  st_nxt.sda_low = 1'b0;
                  if (st_r.state == i2srv_pkg::ST_AACK && st_r.rnw) begin
                     // fetch and present the first bit at once
                     st_nxt.shift     = read_data_byte_i;
                     st_nxt.req.rd    = 1'b1;
                     st_nxt.req.addr  = st_r.register_pointer_byte;
                     st_nxt.sda_low   = ~read_data_byte_i[7];
                     st_nxt.bitcnt    = 4'h1;
                     st_nxt.register_pointer_byte = st_r.register_pointer_byte + 8'h01;
                     st_nxt.state     = i2srv_pkg::ST_RBYT;
                  end else begin
                     st_nxt.state = i2srv_pkg::ST_WBYT;
                  end
               end
            end
            i2srv_pkg::ST_RBYT: begin
               if (line.scl_fall) begin
                  if (st_r.bitcnt == 4'h8) begin
                     st_nxt.sda_low = 1'b0;
                     st_nxt.state   = i2srv_pkg::ST_RACK;
                  end else begin
                     st_nxt.sda_low = ~st_r.shift[3'h7 - st_r.bitcnt[2:0]];
                     st_nxt.bitcnt  = st_r.bitcnt + 4'h1;
                  end
               end
            end
            i2srv_pkg::ST_RACK: begin
               if (line.scl_rise && line.sda) begin
                  st_nxt.state = i2srv_pkg::ST_IDLE;
               end else if (line.scl_fall) begin
                  st_nxt.shift     = read_data_byte_i;
                  st_nxt.req.rd    = 1'b1;
                  st_nxt.req.addr  = st_r.register_pointer_byte;
                  st_nxt.sda_low   = ~read_data_byte_i[7];
                  st_nxt.bitcnt    = 4'h1;
                  st_nxt.register_pointer_byte = st_r.register_pointer_byte + 8'h01;
                  st_nxt.state     = i2srv_pkg::ST_RBYT;
               end
            end
            default: begin
               st_nxt.state = i2srv_pkg::ST_IDLE;
            end
         endcase
      end

      // a read fetch owns req.addr; a colliding write waits for the next phase
      if (st_nxt.req.wr && st_nxt.req.rd) begin
         st_nxt.req.wr = 1'b0;
         st_nxt.pend   = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         st_r.state                 <= i2srv_pkg::ST_IDLE;
         st_r.shift                 <= 8'h00;
         st_r.bitcnt                <= 4'h0;
         st_r.rnw                   <= 1'b0;
         st_r.ptr_phase             <= 1'b0;
         st_r.register_pointer_byte <= `I2SRV_PTR_RST;
         st_r.my_addr               <= `I2SRV_DEF_ADDR;
         st_r.addr_loaded           <= 1'b0;
         st_r.sda_low               <= 1'b0;
         st_r.pend                  <= 1'b0;
         st_r.pend_addr             <= 8'h00;
         st_r.write_data_byte       <= 8'h00;
         st_r.req                   <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sda_o                = 1'b0;
   assign sda_oe_n_o           = ~st_r.sda_low;
   assign req_o                = st_r.req;
   assign bus_target_address_o = st_r.my_addr;
   assign busy_o               = (st_r.state != i2srv_pkg::ST_IDLE);
endmodule : i2srv_slave

// *** i2srv_map.svh ***
`ifndef I2SRV_MAP_SVH
`define I2SRV_MAP_SVH
// bus speeds the front end must follow
`define I2SRV_STD_RATE_KBPS  100
`define I2SRV_FAST_RATE_KBPS 400
`define I2SRV_CLK_MHZ        40
// shortest fast-mode low/high phase is 1300/600 ns; 40 MHz sampling covers it
`define I2SRV_FAST_HIGH_NS   600
`define I2SRV_FAST_HIGH_CYC  ((`I2SRV_FAST_HIGH_NS * `I2SRV_CLK_MHZ) / 1000)
// slave address
`define I2SRV_DEF_ADDR       7'h2b
`define I2SRV_NVS_ADDR_LOC   8'h04
// register pointer reset value
`define I2SRV_PTR_RST        8'h00
`endif

// *** i2srv_pkg.sv ***
package i2srv_pkg;
   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_ADDR = 7'b0000010,
      ST_AACK = 7'b0000100,
      ST_WBYT = 7'b0001000,
      ST_WACK = 7'b0010000,
      ST_RBYT = 7'b0100000,
      ST_RACK = 7'b1000000
   } i2srv_state_e;

   // access towards the device's register space
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } i2srv_req_s;

   // synchronized line samples and edges
   typedef struct packed {
      logic scl;
      logic sda;
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
   } i2srv_line_s;
endpackage : i2srv_pkg

// *** i2srv_line.sv ***
`timescale 1ns/1ps
`include "i2srv_map.svh"
// samples the bus lines and reports edges and start/stop conditions
module i2srv_line (
   // clock and reset
   input  wire logic                  clk_sys_i,
   input  wire logic                  nrst_i,
   // bus lines
   input  wire logic                  scl_i,
   input  wire logic                  sda_i,
   // events
   output i2srv_pkg::i2srv_line_s     line_o
);
   typedef struct packed {
      logic [1:0] scl_h;
      logic [1:0] sda_h;
   } i2srv_lst_s;

   i2srv_lst_s st_r;
   i2srv_lst_s st_nxt;

   always_comb begin
      st_nxt       = st_r;
      st_nxt.scl_h = {st_r.scl_h[0], scl_i};
      st_nxt.sda_h = {st_r.sda_h[0], sda_i};
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         st_r <= '{scl_h: 2'h3, sda_h: 2'h3};
      end else begin
         st_r <= st_nxt;
      end
   end

   always_comb begin
      line_o.scl      = st_r.scl_h[1];
      line_o.sda      = st_r.sda_h[1];
      line_o.scl_rise = st_r.scl_h[0] & ~st_r.scl_h[1];
      line_o.scl_fall = ~st_r.scl_h[0] & st_r.scl_h[1];
      // sda moving while scl is high marks start or stop
      line_o.start    = st_r.scl_h[0] & st_r.scl_h[1] & ~st_r.sda_h[0] & st_r.sda_h[1];
      line_o.stop     = st_r.scl_h[0] & st_r.scl_h[1] & st_r.sda_h[0] & ~st_r.sda_h[1];
   end
endmodule : i2srv_line

// *** i2srv_checker.sv ***
`timescale 1ns/1ps
`include "i2srv_map.svh"
module i2srv_checker (
   // clock and reset
   input wire logic             clk_sys_i,
   input wire logic             nrst_i,
   // bus and core side
   input wire logic             scl_i,
   input wire logic             sda_i,
   input wire logic             sda_o,
   input wire logic             sda_oe_n_o,
   input wire logic             nvs_addr_valid_i,
   input wire logic [6:0]       nvs_addr_i,
   input wire logic             phase_start_i,
   input i2srv_pkg::i2srv_req_s req_o,
   input wire logic [7:0]       read_data_byte_i,
   input wire logic [6:0]       bus_target_address_o,
   input wire logic             busy_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   sequence s_scl_high3;
      scl_i ##1 scl_i ##1 scl_i;
   endsequence
   sequence s_idle3;
      !busy_o ##1 !busy_o ##1 !busy_o;
   endsequence
   a_reset_release: assert property (disable iff (1'b0)
      !nrst_i |=> sda_oe_n_o && !req_o.wr && !req_o.rd) else $error("reset state wrong");
   a_reset_addr: assert property (disable iff (1'b0)
      !nrst_i |=> bus_target_address_o == `I2SRV_DEF_ADDR) else $error("reset address");
   a_nvs_override: assert property (
      $rose(nrst_i) && nvs_addr_valid_i |=> bus_target_address_o == nvs_addr_i)
      else $error("override address");
   a_sda_low_only: assert property (sda_o == 1'b0) else $error("sda driven high");
   a_req_excl: assert property (!(req_o.wr && req_o.rd)) else $error("wr and rd");
   a_wr_one_shot: assert property (req_o.wr |=> !req_o.wr) else $error("wr width");
   a_rd_one_shot: assert property (req_o.rd |=> !req_o.rd) else $error("rd width");
   a_wr_on_phase: assert property (
      req_o.wr |-> $past(phase_start_i)) else $error("write off phase");
   a_drive_scl_low: assert property (
      $fell(sda_oe_n_o) |-> !scl_i) else $error("drive while scl high");
   a_hold_scl_high: assert property (
      s_scl_high3 ##0 $past(nrst_i) |-> $stable(sda_oe_n_o)) else $error("sda moved");
   a_idle_release: assert property (s_idle3 |-> sda_oe_n_o) else $error("idle drive");
endmodule : i2srv_checker
bind i2srv_slave i2srv_checker i2srv_checker_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
   .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
   .nvs_addr_valid_i(nvs_addr_valid_i), .nvs_addr_i(nvs_addr_i),
   .phase_start_i(phase_start_i), .req_o(req_o), .read_data_byte_i(read_data_byte_i),
   .bus_target_address_o(bus_target_address_o), .busy_o(busy_o));

// *** i2srv_host.sv ***
`timescale 1ns/1ps
// bus master model; sda only pulled low or released, scl idles high
module i2srv_host (
   input  wire logic clk_sys_i,
   input  wire logic sda_i,
   output logic      scl_o = 1'b1,
   output logic      sda_oe_n_o = 1'b1
);
   int hp = 56;
   task wt(input int n);
      repeat (n) @(posedge clk_sys_i);
      #2;
   endtask : wt
   // data moves only mid-low so it never reads as start or stop
   task bit_x(input logic b, output logic s);
      wt(hp / 2);
      sda_oe_n_o = b;
      wt(hp / 2);
      scl_o = 1'b1;
      wt(hp / 2);
      s = sda_i;
      wt(hp / 2);
      scl_o = 1'b0;
   endtask : bit_x
   task start;
      wt(hp / 2);
      sda_oe_n_o = 1'b1;
      wt(hp / 2);
      scl_o = 1'b1;
      wt(hp / 2);
      sda_oe_n_o = 1'b0;
      wt(hp / 2);
      scl_o = 1'b0;
   endtask : start
   task stop;
      wt(hp / 2);
      sda_oe_n_o = 1'b0;
      wt(hp / 2);
      scl_o = 1'b1;
      wt(hp / 2);
      sda_oe_n_o = 1'b1;
      wt(hp / 2);
   endtask : stop
   task byte_w(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], s);
      bit_x(1'b1, s);
      ack = !s;
   endtask : byte_w
   task byte_r(output logic [7:0] d, input logic more);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_x(1'b1, d[i]);
      bit_x(!more, s);
   endtask : byte_r
endmodule : i2srv_host

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   logic                  clk_sys_i = 0, nrst_i = 0, phase_start_i = 0, ph_en = 1;
   logic                  nvs_addr_valid_i = 0, ack, scl, h_oe_n, sda_o, sda_oe_n_o, busy_o;
   logic [6:0]            bus_target_address_o, pcnt = '0;
   logic [7:0]            d, rptr = '0, mem [256], emem [256];
   i2srv_pkg::i2srv_req_s req_o;
   logic [15:0]           wq [$];
   int                    err_count = 0, tests_run = 0, seed = 16, rate [2] = '{56, 200};
   wire                   sda = h_oe_n & sda_oe_n_o;
   i2srv_slave i2srv_slave_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .scl_i(scl),
      .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .nvs_addr_valid_i(nvs_addr_valid_i),
      .nvs_addr_i(7'h31), .phase_start_i(phase_start_i), .req_o(req_o),
      .read_data_byte_i(mem[rptr]), .bus_target_address_o(bus_target_address_o), .busy_o(busy_o));
   i2srv_host i2srv_host_inst (.clk_sys_i(clk_sys_i), .sda_i(sda), .scl_o(scl),
      .sda_oe_n_o(h_oe_n));
   initial forever #12.5 clk_sys_i = ~clk_sys_i;
   task check(input string n, input logic [15:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s exp %h seen %h", n, exp, seen);
      end
   endtask : check
   task end_of_test;
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   task do_reset;
      nrst_i = 1'b0;
      repeat (5) @(posedge clk_sys_i);
      #2 nrst_i = 1'b1;
      repeat (2) @(posedge clk_sys_i);
   endtask : do_reset
   task drain;
      for (int i = 0; i < 3000 && wq.size() > 0; i++)
         @(posedge clk_sys_i);
      #2;
      check("drain", wq.size(), 0);
      if (wq.size() > 0) end_of_test();
   endtask : drain
   task xfer_w(input logic [6:0] a, input logic [7:0] p, input int n, input bit hit);
      i2srv_host_inst.start();
      i2srv_host_inst.byte_w({a, 1'b0}, ack);
      check("addr_ack", ack, hit);
      if (hit) begin
         check("busy_on", busy_o, 1);
         i2srv_host_inst.byte_w(p, ack);
         check("ptr_ack", ack, 1);
         for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            emem[p + i[7:0]] = d;
            wq.push_back({p + i[7:0], d});
            i2srv_host_inst.byte_w(d, ack);
            check("data_ack", ack, 1);
         end
      end
      i2srv_host_inst.stop();
   endtask : xfer_w
   task xfer_r(input logic [6:0] a, input logic [7:0] p, input int n, input bit setp);
      if (setp) begin
         i2srv_host_inst.start();
         i2srv_host_inst.byte_w({a, 1'b0}, ack);
         i2srv_host_inst.byte_w(p, ack);
      end
      rptr = p;
      i2srv_host_inst.start();
      i2srv_host_inst.byte_w({a, 1'b1}, ack);
      check("rd_ack", ack, 1);
      for (int i = 0; i < n; i++) begin
         i2srv_host_inst.byte_r(d, i < n - 1);
         check("rdata", d, emem[p + i[7:0]]);
      end
      i2srv_host_inst.stop();
   endtask : xfer_r
   // core side: phase ticks, register reads follow the pointer, writes land on req_o
   always @(posedge clk_sys_i) begin
      pcnt <= pcnt + 7'h01;
      phase_start_i <= #2 ph_en && pcnt == 7'h00;
      if (req_o.rd === 1'b1) begin
         check("rd_addr", req_o.addr, rptr);
         rptr <= rptr + 8'h01;
      end
      if (req_o.wr === 1'b1) begin
         mem[req_o.addr] <= req_o.wdata;
         check("wr", {req_o.addr, req_o.wdata}, wq.size() ? wq.pop_front() : 16'hxxxx);
      end
   end
   initial begin
      for (int i = 0; i < 256; i++)
         mem[i] = i[7:0] ^ 8'h5a;
      emem = mem;
      do_reset();
      check("addr_rst", bus_target_address_o, 7'h2b);
      foreach (rate[k]) begin
         i2srv_host_inst.hp = rate[k];
         xfer_w(7'h2b, k ? 8'h09 : 8'hfe, 3, 1);
         drain();
         xfer_r(7'h2b, k ? 8'h09 : 8'hfe, 3, 1);
      end
      i2srv_host_inst.hp = 56;
      xfer_w(7'h2b, 8'h40, 0, 1);
      drain();
      xfer_r(7'h2b, 8'h40, 2, 0);
      xfer_w(7'h2c, 8'h00, 1, 0);
      check("busy", busy_o, 0);
      ph_en = 1'b0;
      xfer_w(7'h2b, 8'h20, 1, 1);
      i2srv_host_inst.wt(400);
      check("pend", wq.size(), 1);
      ph_en = 1'b1;
      drain();
      nvs_addr_valid_i = 1'b1;
      do_reset();
      check("addr_nvs", bus_target_address_o, 7'h31);
      xfer_w(7'h31, 8'h30, 2, 1);
      xfer_w(7'h2b, 8'h00, 0, 0);
      drain();
      xfer_r(7'h31, 8'h30, 2, 1);
      end_of_test();
   end
endmodule : tb_top
